// file: logic/pec_controller.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "pec_defines.svh"

module pec_controller
  import pec_pkg::*;
#(
  parameter int BLINK_CYC    = `PEC_BLINK_PERIOD_MS * (`PEC_CLK_HZ / 1000),
  parameter int BLINK_ON_CYC = `PEC_BLINK_ON_MS * (`PEC_CLK_HZ / 1000)
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire pec_apb_req_s apb_req,
  output pec_apb_rsp_s      apb_rsp,
  input  wire pec_btn_s     btn,
  input  wire logic         step_tick,
  output pec_out_s          panel
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // lowest pressed choice wins when several arrive together
  function automatic logic [3:0] pick(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] onehot(input logic [2:0] i);
    return 8'h01 << i;
  endfunction

  function automatic logic [3:0] step_wrap(input logic [3:0] st, input logic [3:0] lm1,
                                           input logic fwd);
    logic [3:0] r;
    r = st;
    if (fwd) begin
      r = (st >= lm1) ? 4'h0 : st + 4'h1;
    end else begin
      r = (st == 4'h0) ? lm1 : st - 4'h1;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // pattern store
  // ----------------------------------------------------------------
  pec_rec_s pat_mem [`PEC_NUM_PATTERNS];
  pec_st_s  s_q;
  pec_st_s  s_d;
  logic     mem_we;
  pec_rec_s mem_wdata;
  pec_rec_s cur;

  assign cur = pat_mem[s_q.out.pattern];

  // lower banks have no reset: they model the retained store
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = `PEC_FIRST_BUILTIN; i < `PEC_NUM_PATTERNS; i++) begin
        pat_mem[i] <= '{steps: '0, len_m1: `PEC_DEF_LEN, scale: `PEC_DEF_SCALE};
      end
    end else if (mem_we) begin
      pat_mem[s_q.out.pattern] <= mem_wdata;
    end
  end

  // ----------------------------------------------------------------
  // control
  // ----------------------------------------------------------------
  always_comb begin
    pec_btn_s   press;
    logic [3:0] ch;
    logic       tick;
    logic       blink;
    logic       hv;
    logic       edit;
    logic       stepw;
    logic       tapw;
    logic [3:0] st;
    logic       a;
    logic       b;
    logic       acc;
    pec_rec_s   pr;
    pec_rec_s   w;
    s_d   = s_q;
    press = btn & ~s_q.prev;
    ch    = pick(press.choice);
    if (s_q.lock) begin
      press = '0;
      ch    = 4'h0;
    end
    mem_we    = 1'b0;
    w         = cur;
    pr        = '0;
    s_d.prev  = btn;
    s_d.out.metronome = 1'b0;
    st = 4'h0;
    a  = 1'b0;
    b  = 1'b0;

    s_d.div = (s_q.div >= 32'(BLINK_CYC - 1)) ? 32'h0 : s_q.div + 32'h1;
    tick    = (s_q.div == 32'h0);
    blink   = (s_q.div < 32'(BLINK_ON_CYC));

    edit  = (s_q.state == PEC_ST_EDIT);
    stepw = (s_q.state == PEC_ST_WRITE) && !s_q.out.running;
    tapw  = (s_q.state == PEC_ST_WRITE) && s_q.out.running;
    hv    = (s_q.state == PEC_ST_WRITE) ? s_q.cur_step[3] : s_q.half;

    // sequencer position; the playing half drives the measure led
    if (s_q.out.running && step_tick) begin
      s_d.play_step = step_wrap(s_q.play_step, cur.len_m1, 1'b1);
      if (tapw && cur.steps[s_d.play_step] == 8'h00) begin
        s_d.out.metronome = 1'b1;
      end
    end

    if (press.run) begin
      s_d.out.running = !s_q.out.running;
      s_d.play_step   = 4'h0;
    end

    // mode selection; the mode button owns the choices while held
    if (btn.mode) begin
      if (ch[3] && (ch[2:0] == `PEC_ENTRY_EDIT || ch[2:0] == `PEC_ENTRY_WRITE)) begin
        s_d.is_write = (ch[2:0] == `PEC_ENTRY_WRITE);
        s_d.drum     = `PEC_KICK;
        s_d.half     = 1'b0;
        s_d.cur_step = 4'h0;
        s_d.mod_used = 1'b0;
        if (s_q.out.running && s_q.state != PEC_ST_EDIT && s_q.state != PEC_ST_WRITE) begin
          s_d.state = s_d.is_write ? PEC_ST_WRITE : PEC_ST_EDIT;
          s_d.snap  = cur;
        end else begin
          s_d.state = PEC_ST_BANK;
          s_d.chase = 3'h7;
        end
      end else if (ch[3]) begin
        // other modes leave playback alone
        s_d.state = PEC_ST_OTHER;
      end
    end else begin
      case (s_q.state)
        PEC_ST_BANK: begin
          if (tick) begin
            s_d.chase = s_q.chase - 3'h1;
          end
          if (ch[3]) begin
            s_d.bank  = ch[2:0];
            s_d.state = PEC_ST_PAT;
            s_d.chase = 3'h0;
          end
        end
        PEC_ST_PAT: begin
          if (tick) begin
            s_d.chase = s_q.chase + 3'h1;
          end
          if (ch[3]) begin
            s_d.out.pattern = {s_q.bank, ch[2:0]};
            s_d.snap        = pat_mem[{s_q.bank, ch[2:0]}];
            s_d.state       = s_q.is_write ? PEC_ST_WRITE : PEC_ST_EDIT;
          end
        end
        PEC_ST_EDIT, PEC_ST_WRITE: begin
          if (tapw) begin
            // modifiers fall through untouched here
            s_d.mod_used = 1'b0;
            if (ch[3]) begin
              w.steps[s_q.play_step][ch[2:0]] = 1'b1;
              mem_we = 1'b1;
            end
          end else begin
            if (btn.sel_mod && btn.half_mod) begin
              if (ch[3]) begin
                w.len_m1     = {hv, ch[2:0]};
                mem_we       = 1'b1;
                s_d.mod_used = 1'b1;
              end
            end else if (btn.sel_mod) begin
              if (ch[3] && edit) begin
                s_d.drum     = ch[2:0];
                s_d.mod_used = 1'b1;
              end
            end else if (btn.half_mod) begin
              if (ch[3]) begin
                s_d.mod_used = 1'b1;
                mem_we       = 1'b1;
                case (ch[2:0])
                  `PEC_FN_REV_DRUM: begin
                    for (int i = 0; i < 16; i++) begin
                      w.steps[i][s_q.drum] = s_q.snap.steps[i][s_q.drum];
                    end
                  end
                  `PEC_FN_REV_PAT: w = s_q.snap;
                  `PEC_FN_CLR_DRUM: begin
                    for (int i = 0; i < 16; i++) begin
                      w.steps[i][s_q.drum] = 1'b0;
                    end
                  end
                  `PEC_FN_CLR_PAT: w.steps = '0;
                  default: w.scale = ch[1:0];
                endcase
              end
            end else if (ch[3]) begin
              mem_we = 1'b1;
              if (edit) begin
                w.steps[{s_q.half, ch[2:0]}][s_q.drum] =
                  !cur.steps[{s_q.half, ch[2:0]}][s_q.drum];
              end else begin
                w.steps[s_q.cur_step][ch[2:0]] = !cur.steps[s_q.cur_step][ch[2:0]];
              end
            end
            // a modifier released without a combined press acts alone, except sel_mod in edit
            if (!btn.sel_mod && !btn.half_mod) begin
              s_d.mod_used = 1'b0;
            end
            if (s_q.prev.half_mod && !btn.half_mod && !s_q.mod_used && !btn.sel_mod) begin
              if (edit) begin
                s_d.half = !s_q.half;
              end else begin
                s_d.cur_step = step_wrap(s_q.cur_step, cur.len_m1, 1'b1);
              end
            end
            if (s_q.prev.sel_mod && !btn.sel_mod && !s_q.mod_used && !btn.half_mod && stepw) begin
              s_d.cur_step = step_wrap(s_q.cur_step, cur.len_m1, 1'b0);
            end
          end
        end
        default: ;
      endcase
    end
    mem_wdata = w;

    // ----------------------------------------------------------------
    // panel
    // ----------------------------------------------------------------
    s_d.out.measure_led = s_d.out.running && s_d.play_step[3];
    s_d.out.half_led    = 1'b0;
    s_d.out.step_leds   = 8'h00;
    case (s_d.state)
      PEC_ST_BANK, PEC_ST_PAT: s_d.out.step_leds = onehot(s_d.chase);
      PEC_ST_EDIT: begin
        s_d.out.half_led = s_d.half;
        if (btn.sel_mod && btn.half_mod) begin
          s_d.out.step_leds = onehot(w.len_m1[2:0]);
        end else if (btn.sel_mod) begin
          s_d.out.step_leds = onehot(s_d.drum);
        end else begin
          for (int i = 0; i < 8; i++) begin
            a = w.steps[{s_d.half, 3'(i)}][s_d.drum];
            b = w.steps[{!s_d.half, 3'(i)}][s_d.drum];
            s_d.out.step_leds[i] = (a != b && blink) ? !a : a;
          end
        end
      end
      PEC_ST_WRITE: begin
        s_d.out.half_led = s_d.cur_step[3];
        if (s_d.out.running) begin
          s_d.out.step_leds = w.steps[s_d.play_step];
        end else if (btn.sel_mod && btn.half_mod) begin
          s_d.out.step_leds = onehot(w.len_m1[2:0]);
        end else if (btn.sel_mod || btn.half_mod) begin
          s_d.out.step_leds = onehot(s_d.cur_step[2:0]);
        end else begin
          s_d.out.step_leds = w.steps[s_d.cur_step];
        end
      end
      default: ;
    endcase

    // ----------------------------------------------------------------
    // apb slave: one wait state, answer registered
    // ----------------------------------------------------------------
    acc = apb_req.psel && apb_req.penable;
    s_d.rsp.pready  = acc && !s_q.rsp.pready;
    s_d.rsp.pslverr = 1'b0;
    s_d.rsp.prdata  = 32'h0;
    st = s_q.peek[3:0];
    pr = pat_mem[s_q.peek[9:4]];
    if (acc && !s_q.rsp.pready) begin
      case (apb_req.paddr)
        // bit 3 stays zero so the state code sits alone in the low nibble
        `PEC_REG_STATUS: s_d.rsp.prdata = {8'h00, s_q.play_step, s_q.cur_step,
                                           s_q.out.pattern, s_q.drum, s_q.half,
                                           s_q.out.running, s_q.is_write,
                                           1'b0, s_q.state};
        `PEC_REG_CTRL:      s_d.rsp.prdata = {31'h0, s_q.lock};
        `PEC_REG_PEEK_SEL:  s_d.rsp.prdata = {22'h0, s_q.peek};
        `PEC_REG_PEEK_DATA: s_d.rsp.prdata = {18'h0, pr.scale, pr.len_m1, pr.steps[st]};
        default:            s_d.rsp.pslverr = 1'b1;
      endcase
    end
    if (acc && s_q.rsp.pready && apb_req.pwrite) begin
      case (apb_req.paddr)
        `PEC_REG_CTRL: begin
          s_d.lock = apb_req.pwdata[`PEC_CTRL_LOCK_BIT];
          if (apb_req.pwdata[`PEC_CTRL_RUN_BIT]) begin
            s_d.out.running = !s_q.out.running;
            s_d.play_step   = 4'h0;
          end
        end
        `PEC_REG_PEEK_SEL: s_d.peek = apb_req.pwdata[9:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q          <= '0;
      s_q.state    <= PEC_ST_OTHER;
      s_q.drum     <= `PEC_KICK;
      s_q.lock     <= `PEC_CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp = s_q.rsp;
  assign panel   = s_q.out;

endmodule

// file: logic/pec_defines.svh
`ifndef PEC_DEFINES_SVH
`define PEC_DEFINES_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define PEC_REG_STATUS    12'h000
`define PEC_REG_CTRL      12'h004
`define PEC_REG_PEEK_SEL  12'h008
`define PEC_REG_PEEK_DATA 12'h00c

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define PEC_CTRL_LOCK_BIT 0
`define PEC_CTRL_RUN_BIT  1
`define PEC_CTRL_RST      1'h0
`define PEC_DEF_LEN       4'hf
`define PEC_DEF_SCALE     2'h0
`define PEC_KICK          3'h0

// ----------------------------------------------------------------
// button meanings (choice index, 0 = first choice)
// ----------------------------------------------------------------
`define PEC_ENTRY_EDIT    3'h3
`define PEC_ENTRY_WRITE   3'h4
`define PEC_FN_REV_DRUM   3'h4
`define PEC_FN_REV_PAT    3'h5
`define PEC_FN_CLR_DRUM   3'h6
`define PEC_FN_CLR_PAT    3'h7
`define PEC_FIRST_BUILTIN 6'h20
`define PEC_NUM_PATTERNS  64

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PEC_CLK_HZ          40000000
`define PEC_BLINK_PERIOD_MS 500
`define PEC_BLINK_ON_MS     60

`endif

// file: logic/pec_pkg.sv
package pec_pkg;

  typedef enum logic [2:0] {
    PEC_ST_OTHER = 3'b000,
    PEC_ST_BANK  = 3'b001,
    PEC_ST_PAT   = 3'b010,
    PEC_ST_EDIT  = 3'b011,
    PEC_ST_WRITE = 3'b100
  } pec_state_e;

  typedef struct packed {
    logic [15:0][7:0] steps;
    logic [3:0]       len_m1;
    logic [1:0]       scale;
  } pec_rec_s;

  typedef struct packed {
    logic       mode;
    logic       run;
    logic       sel_mod;
    logic       half_mod;
    logic [7:0] choice;
  } pec_btn_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pec_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } pec_apb_rsp_s;

  typedef struct packed {
    logic [7:0] step_leds;
    logic       half_led;
    logic       measure_led;
    logic       metronome;
    logic       running;
    logic [5:0] pattern;
  } pec_out_s;

  typedef struct packed {
    pec_state_e   state;
    logic         is_write;
    logic [2:0]   bank;
    logic [2:0]   drum;
    logic         half;
    logic [3:0]   cur_step;
    logic [3:0]   play_step;
    logic [2:0]   chase;
    logic [31:0]  div;
    logic         mod_used;
    pec_btn_s     prev;
    pec_rec_s     snap;
    logic         lock;
    logic [9:0]   peek;
    pec_out_s     out;
    pec_apb_rsp_s rsp;
  } pec_st_s;

endpackage

// file: verif/pec_controller_sva.sv
`timescale 1ns/1ps
module pec_controller_chk
  import pec_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst,
  input wire pec_apb_req_s apb_req,
  input wire pec_apb_rsp_s apb_rsp,
  input wire pec_btn_s     btn,
  input wire logic         step_tick,
  input wire pec_out_s     panel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ------
  // lock shadow: a locked panel must not count as a press
  // ------
  logic lock_q;
  logic ctrl_wr;
  assign ctrl_wr = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_rsp.pready
                   & (apb_req.paddr == 12'h004);
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_q <= 1'b0;
    end else if (ctrl_wr) begin
      lock_q <= apb_req.pwdata[0];
    end
  end

  sequence s_idle_entry;
    !panel.running && btn.mode && $rose(btn.choice[3]) && !lock_q;
  endsequence
  sequence s_run_entry;
    panel.running && btn.mode && $rose(btn.choice[3]) && !lock_q;
  endsequence
  sequence s_chase;
    $onehot(panel.step_leds) [*8];
  endsequence

  property p_apb_wait;
    apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready;
  endproperty
  property p_err_ready;
    apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0;
  endproperty
  property p_run_toggle;
    $rose(btn.run) && !lock_q && !ctrl_wr |=> panel.running != $past(panel.running);
  endproperty
  property p_run_hold;
    !$rose(btn.run) && !ctrl_wr |=> $stable(panel.running);
  endproperty
  property p_entry_run;
    s_run_entry |=> $stable(panel.pattern) && panel.running;
  endproperty
  property p_prompt;
    s_idle_entry |=> s_chase;
  endproperty
  property p_metro;
    panel.metronome |-> panel.running ##1 !panel.metronome;
  endproperty
  property p_measure;
    panel.measure_led |-> panel.running;
  endproperty

  a_apb_wait: assert property (p_apb_wait) else $error("access not answered");
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  a_run_toggle: assert property (p_run_toggle)
    else $error("run press did not toggle");
  a_run_hold: assert property (p_run_hold)
    else $error("running changed unasked");
  a_entry_run: assert property (p_entry_run)
    else $error("entry disturbed playing pattern");
  a_prompt: assert property (p_prompt)
    else $error("no chase on idle entry");
  a_metro: assert property (p_metro)
    else $error("bad metronome pulse");
  a_measure: assert property (p_measure)
    else $error("measure lit while stopped");
endmodule

bind pec_controller pec_controller_chk u_chk (
  .clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .btn(btn),
  .step_tick(step_tick), .panel(panel));

// file: verif/pec_user.sv
`timescale 1ns/1ps
module pec_user
  import pec_pkg::*;
(
  input wire logic clk,
  output pec_btn_s btn,
  output logic     step_tick
);
  int tick_cnt = 0;
  initial btn = '0;
  initial step_tick = 1'b0;

  // ------
  // tempo: one step every 16 clocks
  // ------
  always @(posedge clk) begin
    tick_cnt <= (tick_cnt == 15) ? 0 : tick_cnt + 1;
    step_tick <= (tick_cnt == 15);
  end

  // hold modifiers, tap the hit buttons, then let go of everything
  task automatic act(input pec_btn_s hold, input pec_btn_s hit);
    @(posedge clk) btn <= hold;
    @(posedge clk) btn <= hold | hit;
    @(posedge clk) btn <= hold;
    @(posedge clk) btn <= '0;
  endtask
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
module tb
  import pec_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  pec_apb_req_s req = '0;
  pec_apb_rsp_s rsp;
  pec_btn_s     btn;
  logic         tick;
  pec_out_s     panel;
  logic [31:0]  r;
  logic         err;
  logic [7:0]   m [16];
  int           fail_count = 0;
  int           comparisons = 0;
  int           n;
  int           cnt;

  always #12.5 clk = ~clk;

  pec_controller #(.BLINK_CYC(40), .BLINK_ON_CYC(8)) dut (
    .clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp), .btn(btn),
    .step_tick(tick), .panel(panel));
  pec_user usr (.clk(clk), .btn(btn), .step_tick(tick));

  // ------
  // helpers
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk) req <= {1'b1, 1'b0, w, a, d};
    @(posedge clk) req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1 && k++ < 20);
    r = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    chk(k < 20, 1);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] msk, input logic [31:0] exp);
    apb(0, a, 0);
    chk(r & msk, exp);
  endtask

  // peek one step of the edited pattern (bank five, slot one)
  task automatic pk(input int s);
    apb(1, 12'h008, {22'h0, 6'h20, s[3:0]});
    apb(0, 12'h00c, 0);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end

  // ------
  // main sequence
  // ------
  initial begin
    void'($urandom(32'h5323));
    m = '{default: 8'h0};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc(12'h000, 32'hffffff, 0);
    rc(12'h004, 32'hffffffff, 0);
    rc(12'h010, 32'hffffffff, 0);
    chk(err, 1);
    usr.act(12'h800, 12'h008);
    rc(12'h000, 32'h7, 1);
    usr.act(0, 12'h010);
    rc(12'h000, 32'h7, 2);
    usr.act(0, 12'h001);
    rc(12'h000, 32'hfff7, 32'h8003);
    pk(0);
    chk(r[13:0], 14'h0f00);
    n = $urandom_range(7, 0);
    usr.act(0, 12'h001 << n);
    m[n] ^= 8'h01;
    pk(n);
    chk(r[7:0], m[n]);
    usr.act(12'h100, 0);
    rc(12'h000, 32'h40, 32'h40);
    chk(panel.half_led, 1);
    usr.act(0, 12'h001 << n);
    m[n+8] ^= 8'h01;
    pk(n + 8);
    chk(r[7:0], m[n+8]);
    // upper half off, lower half on: led dark but blinks high briefly
    usr.act(0, 12'h001 << n);
    cnt = 0;
    repeat (40) @(posedge clk) cnt += panel.step_leds[n];
    chk(cnt, 8);
    // both halves on again: steady on
    usr.act(0, 12'h001 << n);
    cnt = 0;
    repeat (40) @(posedge clk) cnt += panel.step_leds[n];
    chk(cnt, 40);
    usr.act(12'h200, 12'h004);
    rc(12'h000, 32'h380, 32'h100);
    usr.act(0, 12'h001 << n);
    usr.act(12'h100, 12'h010);
    pk(n + 8);
    chk(r[7:0], m[n+8]);
    usr.act(12'h100, 12'h020);
    m = '{default: 8'h0};
    pk(n);
    chk(r[7:0], 0);
    usr.act(0, 12'h001 << n);
    usr.act(12'h100, 12'h040);
    pk(n + 8);
    chk(r[7:0], 0);
    usr.act(0, 12'h001 << n);
    usr.act(12'h100, 12'h080);
    pk(n + 8);
    chk(r[7:0], 0);
    for (int k = 0; k < 4; k++) begin
      usr.act(12'h100, 12'h001 << k);
      pk(0);
      chk(r[13:12], k[1:0]);
    end
    usr.act(12'h300, 12'h008);
    pk(0);
    chk(r[11:8], 4'hb);
    usr.act(0, 12'h400);
    rc(12'h000, 32'h20, 32'h20);
    usr.act(12'h800, 12'h008);
    rc(12'h000, 32'h27, 32'h21);
    usr.act(0, 12'h010);
    usr.act(0, 12'h001);
    usr.act(12'h800, 12'h001);
    usr.act(12'h800, 12'h008);
    rc(12'h000, 32'hfc27, 32'h8023);
    usr.act(12'h800, 12'h001);
    usr.act(12'h800, 12'h010);
    rc(12'h000, 32'h37, 32'h34);
    usr.act(12'h100, 0);
    usr.act(12'h200, 0);
    rc(12'h000, 32'hf0000, 0);
    usr.act(0, 12'h400);
    usr.act(12'h100, 0);
    rc(12'h000, 32'hf0020, 32'h10000);
    usr.act(12'h200, 0);
    rc(12'h000, 32'hf0000, 0);
    usr.act(12'h200, 0);
    rc(12'h000, 32'hf0000, 32'hb0000);
    usr.act(0, 12'h004);
    m[11] ^= 8'h04;
    chk(panel.step_leds, m[11]);
    pk(11);
    chk(r[7:0], m[11]);
    usr.act(12'h100, 12'h002);
    pk(0);
    chk(r[13:12], 2'h1);
    apb(1, 12'h004, 1);
    usr.act(0, 12'h400);
    rc(12'h004, 32'hffffffff, 1);
    rc(12'h000, 32'h20, 0);
    apb(1, 12'h004, 2);
    rc(12'h004, 32'hffffffff, 0);
    rc(12'h000, 32'h20, 32'h20);
    cnt = 0;
    repeat (384) @(posedge clk) cnt += panel.metronome;
    chk(cnt >= 21 && cnt <= 23, 1);
    test_done();
  end
endmodule
